// file: rtl/ctm_pkg.sv
// Shared constants and types for the cascaded 16-bit timer block.
// Assumes a single 200 MHz system clock and synchronous pin inputs.
package ctm_pkg;

  // Counter geometry.
  localparam int unsigned CTM_BYTE_W = 8;
  localparam int unsigned CTM_CNT_W  = 16;
  localparam int unsigned CTM_PRE_W  = 11;

  // Counter values that the compare logic uses.
  localparam logic [CTM_CNT_W-1:0]  CTM_CNT_MAX   = 16'hFFFF;
  localparam logic [CTM_CNT_W-1:0]  CTM_CNT_RST   = 16'h0000;
  localparam logic [CTM_BYTE_W-1:0] CTM_BYTE_MAX  = 8'hFF;
  localparam logic [CTM_BYTE_W-1:0] CTM_BYTE_ZERO = 8'h00;

  // Values after reset.
  localparam logic                  CTM_FLOP_RST  = 1'b0;
  localparam logic [CTM_CNT_W-1:0]  CTM_REG16_RST = 16'h0000;
  localparam logic [CTM_BYTE_W-1:0] CTM_REG8_RST  = 8'h00;
  localparam logic [CTM_PRE_W-1:0]  CTM_PRE_RST   = 11'h000;

  // Prescaler tap masks: a tick fires when the masked bits are all ones.
  localparam logic [CTM_PRE_W-1:0]  CTM_MASK_D11  = 11'h7FF;
  localparam logic [CTM_PRE_W-1:0]  CTM_MASK_D7   = 11'h07F;
  localparam logic [CTM_PRE_W-1:0]  CTM_MASK_D5   = 11'h01F;
  localparam logic [CTM_PRE_W-1:0]  CTM_MASK_D3   = 11'h007;
  localparam logic [CTM_PRE_W-1:0]  CTM_MASK_D1   = 11'h001;

  // Operating modes of the cascaded pair.
  typedef enum logic [3:0] {
    CTM_MODE_EVENT  = 4'h1,
    CTM_MODE_PWM    = 4'h2,
    CTM_MODE_PULSE  = 4'h4,
    CTM_MODE_WARMUP = 4'h8
  } ctm_mode_t;

  // Source clock of the counter in the timer-driven modes.
  typedef enum logic [2:0] {
    CTM_SRC_DIV11 = 3'h0,
    CTM_SRC_DIV7  = 3'h1,
    CTM_SRC_DIV5  = 3'h2,
    CTM_SRC_DIV3  = 3'h3,
    CTM_SRC_LOW   = 3'h4,
    CTM_SRC_DIV1  = 3'h5,
    CTM_SRC_DIV0  = 3'h6,
    CTM_SRC_PIN   = 3'h7
  } ctm_src_t;

endpackage : ctm_pkg

// file: rtl/ctm_cnt_if.sv
// Carrier between the timer control and its cascaded counter.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface ctm_cnt_if;
  import ctm_pkg::*;

  logic                 inc;
  logic                 clr;
  logic [CTM_CNT_W-1:0] count;

  modport ctl (output inc, output clr, input count);
  modport cnt (input inc, input clr, output count);
endinterface : ctm_cnt_if

// file: rtl/ctm_counter.sv
// Two 8-bit up-counters cascaded into one 16-bit up-counter.
// Assumes inc and clr are qualified by the controller; clear wins.
`timescale 1ns/1ps
module ctm_counter (
  // Clock and reset.
  input  wire logic  i_clk,
  input  wire logic  i_rst_n,
  // Controller side.
  ctm_cnt_if.cnt     cnt_if
);
  import ctm_pkg::*;

  typedef struct packed {
    logic [1:0][CTM_BYTE_W-1:0] stage;
  } ctm_cnt_state_t;

  ctm_cnt_state_t st_ff;
  ctm_cnt_state_t nxt_st;
  logic [2:0]     carry;

  // The high byte stage steps when the low stage wraps, forming one 16-bit counter.
  always_comb
  begin
    nxt_st   = st_ff;
    carry[0] = cnt_if.inc;
    for (int i = 0; i < 2; i++)
    begin
      carry[i+1] = carry[i] && (st_ff.stage[i] == CTM_BYTE_MAX);
      if (cnt_if.clr)
      begin
        nxt_st.stage[i] = CTM_BYTE_ZERO;
      end
      else if (carry[i])
      begin
        nxt_st.stage[i] = st_ff.stage[i] + 8'h01;
      end
    end
  end

  // State register.
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign cnt_if.count = st_ff.stage;

  AST_CARRY: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (cnt_if.inc && !cnt_if.clr && st_ff.stage[0] == CTM_BYTE_MAX) |=>
    (st_ff.stage[0] == CTM_BYTE_ZERO && st_ff.stage[1] == $past(st_ff.stage[1]) + 8'h01))
    else $error("Low byte wrap did not carry into the high byte.");

endmodule : ctm_counter

// file: rtl/ctm_timer.sv
// Cascaded 16-bit timer: event counter, PWM, pulse generator and warm-up counter.
// Assumes synchronous pin inputs and byte write strobes from a host at plain ports.
`timescale 1ns/1ps
module ctm_timer (
  // Clock and reset.
  input  wire logic                       i_clk,
  input  wire logic                       i_rst_n,
  // Control bits.
  input  wire ctm_pkg::ctm_mode_t         i_mode,
  input  wire ctm_pkg::ctm_src_t          i_src_sel,
  input  wire logic                       i_upper_run_bit,
  input  wire logic                       i_flop_initial_value,
  input  wire logic                       i_warmup_to_slow,
  input  wire logic                       i_low_freq_tick,
  // Byte writes.
  input  wire logic [7:0]                 i_wdata,
  input  wire logic                       i_period_low_byte_we,
  input  wire logic                       i_period_high_byte_we,
  input  wire logic                       i_width_low_byte_we,
  input  wire logic                       i_width_high_byte_we,
  // Pins.
  input  wire logic                       i_event_count_input,
  output logic                            o_pwm_output_pin,
  output logic                            o_pulse_gen_output_pin,
  // Status.
  output logic                            o_cascade_match_interrupt,
  output logic [ctm_pkg::CTM_CNT_W-1:0]   o_width_read,
  output logic [ctm_pkg::CTM_CNT_W-1:0]   o_count
);
  import ctm_pkg::*;

  typedef struct packed {
    logic                  flop;
    logic                  pwm_pin;
    logic                  ppg_pin;
    logic                  irq;
    logic                  evt_prev;
    logic                  run_prev;
    logic                  init_prev;
    logic [CTM_BYTE_W-1:0] period_lo;
    logic [CTM_BYTE_W-1:0] width_lo;
    logic [CTM_CNT_W-1:0]  period;
    logic [CTM_CNT_W-1:0]  duty_buf;
    logic [CTM_CNT_W-1:0]  duty_act;
    logic [CTM_CNT_W-1:0]  width_rd;
    logic [CTM_CNT_W-1:0]  count_rd;
    logic [CTM_PRE_W-1:0]  pre;
  } ctm_top_state_t;

  localparam ctm_top_state_t CTM_TOP_RST = '{
    flop: CTM_FLOP_RST, pwm_pin: ~CTM_FLOP_RST, ppg_pin: ~CTM_FLOP_RST, irq: 1'b0,
    evt_prev: 1'b0, run_prev: 1'b0, init_prev: 1'b0,
    period_lo: CTM_REG8_RST, width_lo: CTM_REG8_RST, period: CTM_REG16_RST,
    duty_buf: CTM_REG16_RST, duty_act: CTM_REG16_RST, width_rd: CTM_REG16_RST,
    count_rd: CTM_CNT_RST, pre: CTM_PRE_RST};

  ctm_top_state_t st_ff;
  ctm_top_state_t nxt_st;
  ctm_cnt_if      cnt_if ();

  logic                 evt_fall;
  logic                 src_tick;
  logic                 tick;
  logic                 running;
  logic                 ovf_load;
  logic [CTM_CNT_W-1:0] new_width;
  logic [CTM_CNT_W-1:0] cnt;

  // Picks the enable pulse of the selected source; the same decode serves fast-bound warm-up.
  function automatic logic ctm_src_tick(input ctm_src_t sel,
                                        input logic [CTM_PRE_W-1:0] pre,
                                        input logic lf, input logic pin_fall);
    logic t;
    t = 1'b0;
    case (sel)
      CTM_SRC_DIV11: t = ((pre & CTM_MASK_D11) == CTM_MASK_D11);
      CTM_SRC_DIV7:  t = ((pre & CTM_MASK_D7) == CTM_MASK_D7);
      CTM_SRC_DIV5:  t = ((pre & CTM_MASK_D5) == CTM_MASK_D5);
      CTM_SRC_DIV3:  t = ((pre & CTM_MASK_D3) == CTM_MASK_D3);
      CTM_SRC_LOW:   t = lf;
      CTM_SRC_DIV1:  t = ((pre & CTM_MASK_D1) == CTM_MASK_D1);
      CTM_SRC_DIV0:  t = 1'b1;
      CTM_SRC_PIN:   t = pin_fall;
      default:       t = 1'b0;
    endcase
    return t;
  endfunction : ctm_src_tick

  ctm_counter u_counter (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .cnt_if  (cnt_if)
  );

  // Edge and tick decode. Event mode always counts falling pin edges.
  always_comb
  begin
    cnt      = cnt_if.count;
    running  = i_upper_run_bit;
    evt_fall = st_ff.evt_prev && !i_event_count_input;
    src_tick = ctm_src_tick(i_src_sel, st_ff.pre, i_low_freq_tick, evt_fall);
    tick     = 1'b0;
    case (i_mode)
      CTM_MODE_EVENT:  tick = evt_fall;
      // Slow-bound warm-up times the low oscillator; fast-bound uses the chosen divider.
      CTM_MODE_WARMUP: tick = i_warmup_to_slow ? i_low_freq_tick : src_tick;
      default:         tick = src_tick;
    endcase
    tick = tick && running;
  end

  // Next state: compare logic per mode, register writes and the output flop.
  always_comb
  begin
    nxt_st       = st_ff;
    cnt_if.inc   = 1'b0;
    cnt_if.clr   = !running;
    ovf_load     = 1'b0;
    nxt_st.irq   = 1'b0;
    nxt_st.pre   = st_ff.pre + 11'h001;
    nxt_st.evt_prev  = i_event_count_input;
    nxt_st.run_prev  = running;
    nxt_st.init_prev = i_flop_initial_value;
    new_width    = {i_wdata, st_ff.width_lo};

    if (tick)
    begin
      case (i_mode)
        CTM_MODE_EVENT:
        begin
          if (cnt == st_ff.period)
          begin
            cnt_if.clr = 1'b1;
            nxt_st.irq = 1'b1;
          end
          else
            cnt_if.inc = 1'b1;
        end
        CTM_MODE_PWM:
        begin
          if (cnt == st_ff.duty_act)
            nxt_st.flop = ~nxt_st.flop;
          if (cnt == CTM_CNT_MAX)
          begin
            nxt_st.flop = ~nxt_st.flop;
            cnt_if.clr  = 1'b1;
            nxt_st.irq  = 1'b1;
            ovf_load    = 1'b1;
          end
          else
            cnt_if.inc = 1'b1;
        end
        CTM_MODE_PULSE:
        begin
          if (cnt == st_ff.period)
          begin
            nxt_st.flop = ~st_ff.flop;
            cnt_if.clr  = 1'b1;
            nxt_st.irq  = 1'b1;
          end
          else
          begin
            if (cnt == st_ff.duty_act)
              nxt_st.flop = ~st_ff.flop;
            cnt_if.inc = 1'b1;
          end
        end
        default:
        begin
          // Low period byte is ignored so the match lands on a byte boundary.
          if (cnt == {st_ff.period[CTM_CNT_W-1:CTM_BYTE_W], CTM_BYTE_ZERO})
          begin
            cnt_if.clr = 1'b1;
            nxt_st.irq = 1'b1;
          end
          else
            cnt_if.inc = 1'b1;
        end
      endcase
    end

    // Low bytes wait in staging; the high byte commits the whole word.
    if (i_period_low_byte_we)
      nxt_st.period_lo = i_wdata;
    if (i_period_high_byte_we)
      nxt_st.period = {i_wdata, st_ff.period_lo};
    if (i_width_low_byte_we)
      nxt_st.width_lo = i_wdata;
    if (i_width_high_byte_we)
    begin
      nxt_st.duty_buf = new_width;
      if (!(running && i_mode == CTM_MODE_PWM))
        nxt_st.duty_act = new_width;
    end
    // A write landing on the overflow itself loads the fresh word; software avoids it.
    if (ovf_load)
      nxt_st.duty_act = nxt_st.duty_buf;

    // Start loads the initial level; after a stop only a later change reloads it.
    if (running && !st_ff.run_prev)
      nxt_st.flop = i_flop_initial_value;
    else if (!running && !st_ff.run_prev && (i_flop_initial_value != st_ff.init_prev))
      nxt_st.flop = i_flop_initial_value;

    nxt_st.pwm_pin  = ~nxt_st.flop;
    nxt_st.ppg_pin  = ~nxt_st.flop;
    nxt_st.width_rd = nxt_st.duty_act;
    nxt_st.count_rd = cnt;
  end

  // State register; reset clears the output flop.
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      st_ff <= CTM_TOP_RST;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign o_pwm_output_pin          = st_ff.pwm_pin;
  assign o_pulse_gen_output_pin    = st_ff.ppg_pin;
  assign o_cascade_match_interrupt = st_ff.irq;
  assign o_width_read              = st_ff.width_rd;
  assign o_count                   = st_ff.count_rd;

  default clocking ctm_cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  AST_EVT_STEP: assert property (
    (i_mode == CTM_MODE_EVENT && running && evt_fall && cnt != st_ff.period)
      |=> (cnt_if.count == $past(cnt) + 16'h0001))
    else $error("Event edge did not advance the counter by one.");
  AST_EVT_MATCH: assert property (
    (i_mode == CTM_MODE_EVENT && running && evt_fall && cnt == st_ff.period)
      |=> (o_cascade_match_interrupt && cnt_if.count == CTM_CNT_RST))
    else $error("Event period match did not interrupt and clear.");
  AST_PWM_OVF: assert property (
    (i_mode == CTM_MODE_PWM && tick && cnt == CTM_CNT_MAX && st_ff.duty_act != CTM_CNT_MAX)
      |=> (o_cascade_match_interrupt && st_ff.flop != $past(st_ff.flop)
           && cnt_if.count == CTM_CNT_RST))
    else $error("PWM overflow did not toggle, clear and interrupt.");
  AST_PIN_INV: assert property (
    o_pwm_output_pin == ~st_ff.flop && o_pulse_gen_output_pin == ~st_ff.flop)
    else $error("Output pins are not the inverse of the output flop.");
  AST_START_LEVEL: assert property (
    (running && !st_ff.run_prev) |=> (st_ff.flop == $past(i_flop_initial_value)))
    else $error("Start did not load the initial output level.");
  AST_DUTY_HOLD: assert property (
    (i_mode == CTM_MODE_PWM && running && st_ff.run_prev && !ovf_load)
      |=> $stable(o_width_read) [*1] ##1 1'b1)
    else $error("Duty readback changed while running without overflow.");
  AST_STOP_HOLD: assert property (
    (!running && st_ff.run_prev) |=> $stable(st_ff.flop) && $stable(o_pwm_output_pin))
    else $error("Output level moved in the stop cycle.");
  // The start cycle is left out: there the initial level wins over a width match at zero.
  AST_PULSE_WIDTH: assert property (
    (i_mode == CTM_MODE_PULSE && tick && st_ff.run_prev
      && cnt == st_ff.duty_act && cnt != st_ff.period)
      |=> (st_ff.flop != $past(st_ff.flop)) && (o_pulse_gen_output_pin == $past(st_ff.flop)))
    else $error("Width match did not toggle the pulse output.");
  AST_WARM_MATCH: assert property (
    (i_mode == CTM_MODE_WARMUP && tick
      && cnt == {st_ff.period[CTM_CNT_W-1:CTM_BYTE_W], CTM_BYTE_ZERO})
      |=> (o_cascade_match_interrupt && cnt_if.count == CTM_CNT_RST))
    else $error("Warm-up upper-byte match did not interrupt and clear.");

endmodule : ctm_timer

// file: dv/ctm_evt_src.sv
// Behavioural event pulse source that drives the timer's event input pin.
// Assumes one system clock; a request loads a count of falling edges to emit.
`timescale 1ns/1ps
module ctm_evt_src (
  // Clock and reset.
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  // Request from the bench.
  input  wire logic        i_go,
  input  wire logic [15:0] i_edges,
  // Pin and status.
  output logic             o_event,
  output logic             o_busy
);
  logic [15:0] left_ff;
  logic [3:0]  phase_ff;

  // Busy while edges remain, so the bench can wait on it with a bound.
  assign o_busy = (left_ff != 16'h0000);

  // Each edge is 8 cycles high then 8 low; slower than needed, never faster.
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      left_ff  <= 16'h0000;
      phase_ff <= 4'h0;
      o_event  <= 1'b1;
    end
    else if (i_go)
    begin
      left_ff  <= i_edges;
      phase_ff <= 4'h0;
    end
    else if (left_ff != 16'h0000)
    begin
      phase_ff <= phase_ff + 4'h1;
      if (phase_ff == 4'h7)
        o_event <= 1'b0;
      if (phase_ff == 4'hF)
      begin
        o_event <= 1'b1;
        left_ff <= left_ff - 16'h0001;
      end
    end
  end
endmodule : ctm_evt_src

// file: dv/ctm_timer_tb.sv
// Self-checking bench for the cascaded timer, run mode by mode through plain ports.
// Assumes the event pin is driven by the partner source model.
`timescale 1ns/1ps
module ctm_timer_tb;
  import ctm_pkg::*;

  logic        clk     = 1'b0;
  logic        rst_n   = 1'b0;
  ctm_mode_t   mode    = CTM_MODE_EVENT;
  ctm_src_t    src     = CTM_SRC_DIV0;
  logic        run     = 1'b0;
  logic        fiv     = 1'b0;
  logic        to_slow = 1'b0;
  logic        lf_tick = 1'b0;
  logic [1:0]  lf_div  = 2'h0;
  logic [7:0]  wdata   = 8'h00;
  logic [3:0]  we      = 4'h0;
  logic        go      = 1'b0;
  logic [15:0] edges   = 16'h0000;
  logic        evt;
  logic        busy;
  logic        pwm_pin;
  logic        pg_pin;
  logic        irq;
  logic [15:0] wread;
  logic [15:0] cnt;
  int          err_total = 0;
  int          checked   = 0;
  int          irq_n     = 0;
  int          cyc;
  int          low;
  int          i;

  // Clock at 200 MHz.
  always #2.5 clk = ~clk;

  // Low-frequency tick every fourth cycle, driven off the sampling edge.
  always @(negedge clk)
  begin
    lf_div  <= lf_div + 2'h1;
    lf_tick <= (lf_div == 2'h3);
  end

  // Interrupt pulses are counted off the launching edge so each is seen once, settled.
  always @(negedge clk)
    if (irq === 1'b1)
      irq_n <= irq_n + 1;

  ctm_timer dut (
    .i_clk                     (clk),
    .i_rst_n                   (rst_n),
    .i_mode                    (mode),
    .i_src_sel                 (src),
    .i_upper_run_bit           (run),
    .i_flop_initial_value      (fiv),
    .i_warmup_to_slow          (to_slow),
    .i_low_freq_tick           (lf_tick),
    .i_wdata                   (wdata),
    .i_period_low_byte_we      (we[0]),
    .i_period_high_byte_we     (we[1]),
    .i_width_low_byte_we       (we[2]),
    .i_width_high_byte_we      (we[3]),
    .i_event_count_input       (evt),
    .o_pwm_output_pin          (pwm_pin),
    .o_pulse_gen_output_pin    (pg_pin),
    .o_cascade_match_interrupt (irq),
    .o_width_read              (wread),
    .o_count                   (cnt)
  );

  ctm_evt_src src_model (
    .i_clk   (clk),
    .i_rst_n (rst_n),
    .i_go    (go),
    .i_edges (edges),
    .o_event (evt),
    .o_busy  (busy)
  );

  task test_done();
    $display("summary: %0d checks, %0d mismatches", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : test_done

  task chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp)
    begin
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
      err_total++;
    end
  endtask : chk

  // Low byte then high byte; sel 0 is the period word, 2 the width word.
  task wr16(input int sel, input logic [15:0] v);
    @(negedge clk);
    wdata = v[7:0];
    we    = 4'(4'h1 << sel);
    @(negedge clk);
    wdata = v[15:8];
    we    = 4'(4'h2 << sel);
    @(negedge clk);
    we    = 4'h0;
  endtask : wr16

  task wait_n(input int n);
    repeat (n) @(negedge clk);
  endtask : wait_n

  // The stop stands for one edge so the counter clears and the next run is a fresh start.
  task mode_set(input ctm_mode_t m);
    @(negedge clk);
    run  = 1'b0;
    mode = m;
    @(negedge clk);
  endtask : mode_set

  // Sends n falling edges on the event pin and waits for the source to finish.
  task pulses(input logic [15:0] n);
    @(negedge clk);
    edges = n;
    go    = 1'b1;
    @(negedge clk);
    go    = 1'b0;
    for (i = 0; i < 70000 && busy === 1'b1; i++)
      @(negedge clk);
    if (busy !== 1'b0)
    begin
      $display("unexpected source busy: expected 0, seen %b", busy);
      err_total++;
      test_done();
    end
    else
      wait_n(4);
  endtask : pulses

  // Cycles to the next interrupt, and cycles the pulse pin spent low meanwhile.
  task gap(input int lim);
    int k;
    cyc = 0;
    low = 0;
    for (k = 0; k < lim; k++)
    begin
      @(negedge clk);
      cyc++;
      if (pg_pin === 1'b0)
        low++;
      if (irq === 1'b1)
        return;
    end
    $display("unexpected interrupt wait: expected within %0d, seen none", lim);
    err_total++;
    test_done();
  endtask : gap

  // Main sequence: reset, event, pulse, warm-up, then the long PWM period.
  initial
  begin
    wait_n(3);
    chk("pwm pin in reset", 16'h0001, {15'h0, pwm_pin});
    chk("pulse pin in reset", 16'h0001, {15'h0, pg_pin});
    chk("count in reset", 16'h0000, cnt);
    rst_n = 1'b1;
    $display("test reset done");

    mode_set(CTM_MODE_EVENT);
    wr16(0, 16'h0101);
    run = 1'b1;
    pulses(16'h0101);
    chk("event count", 16'h0101, cnt);
    chk("early interrupts", 16'h0000, 16'(irq_n));
    pulses(16'h0001);
    chk("match interrupts", 16'h0001, 16'(irq_n));
    chk("count after match", 16'h0000, cnt);
    pulses(16'h0002);
    chk("count after restart", 16'h0002, cnt);
    $display("test event done");

    mode_set(CTM_MODE_PULSE);
    wr16(2, 16'h0004);
    wr16(0, 16'h0009);
    run = 1'b1;
    gap(200);
    gap(200);
    chk("pulse period", 16'h0009 + 16'h0001, 16'(cyc));
    chk("pulse low time", 16'h0009 - 16'h0004, 16'(low));
    wr16(0, 16'h0013);
    gap(200);
    gap(200);
    chk("new pulse period", 16'h0013 + 16'h0001, 16'(cyc));
    $display("test pulse done");

    mode_set(CTM_MODE_WARMUP);
    wr16(0, 16'h01FF);
    src = CTM_SRC_DIV3;
    run = 1'b1;
    gap(2400);
    gap(2400);
    chk("warm-up fast period", (16'h0100 + 16'h0001) * 16'h0008, 16'(cyc));
    mode_set(CTM_MODE_WARMUP);
    to_slow = 1'b1;
    run     = 1'b1;
    gap(2400);
    gap(2400);
    chk("warm-up slow period", (16'h0100 + 16'h0001) * 16'h0004, 16'(cyc));
    $display("test warm-up done");

    mode_set(CTM_MODE_PWM);
    src = CTM_SRC_DIV0;
    wr16(2, 16'h0010);
    wait_n(2);
    chk("duty while stopped", 16'h0010, wread);
    run = 1'b1;
    wait_n(3);
    chk("pwm pin at start", 16'h0001, {15'h0, pwm_pin});
    for (i = 0; i < 40 && pwm_pin !== 1'b0; i++)
      @(negedge clk);
    chk("pwm pin after duty", 16'h0000, {15'h0, pwm_pin});
    // The port latches are taken as 1, so the pins show the timer's own levels.
    chk("pulse pin mirrors", {15'h0, pwm_pin}, {15'h0, pg_pin});
    wr16(2, 16'h0020);
    wait_n(3);
    chk("duty read while running", 16'h0010, wread);
    gap(70000);
    wait_n(2);
    chk("pwm pin after overflow", 16'h0001, {15'h0, pwm_pin});
    chk("duty after overflow", 16'h0020, wread);
    run = 1'b0;
    wait_n(40);
    chk("pwm pin held on stop", 16'h0001, {15'h0, pwm_pin});
    fiv = 1'b1;
    wait_n(3);
    chk("pwm pin after new level", 16'h0000, {15'h0, pwm_pin});
    $display("test pwm done");
    test_done();
  end
endmodule : ctm_timer_tb
